//--- logic/fifo_pkg.sv
// Shared constants and types for the 18-bit flagged FIFO
`default_nettype none
package fifo_pkg;
   localparam int DATA_W = 18;
   localparam int OFS_W = 12;
   localparam int DEPTH_DEF = 256;
   localparam int ADDR_W = 8;
   // Register byte addresses
   localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
   localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
   localparam logic [ADDR_W-1:0] OFFSETS_OFS = 8'h08;
   // Field positions
   localparam int CTRL_CHAIN_BIT = 0;
   localparam int ST_COUNT_LSB = 0;
   localparam int ST_FLAGS_LSB = 16;
   localparam int ST_MODE_LSB = 21;
   localparam int OFS_EMPTY_LSB = 0;
   localparam int OFS_FULL_LSB = 16;
   // Reset values
   localparam logic CTRL_CHAIN_RST = 1'b0;
   localparam logic [31:0] RDATA_RST = 32'h0000_0000;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Read clock transitions before a first word falls through
   localparam int FT_TRANSITIONS = 3;
   typedef enum logic {SEL_EMPTY = 1'b0, SEL_FULL = 1'b1} ofs_sel_t;
   // Default almost-empty/almost-full offset per depth variant
   function automatic logic [OFS_W-1:0] default_offset(input int depth);
      if (depth <= 256) begin
         return 12'h01F;
      end else if (depth <= 512) begin
         return 12'h03F;
      end
      return 12'h07F;
   endfunction : default_offset
endpackage : fifo_pkg
`default_nettype wire

//--- logic/dual_clock_fifo_18bit_flags.sv
// Flagged FIFO with pin-sampled write and read clocks and an AXI4-Lite status port
//
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`default_nettype none
module dual_clock_fifo_18bit_flags
   import fifo_pkg::*;
#(
   parameter int DEPTH = DEPTH_DEF,
   parameter bit DOUBLE_SYNC = 1'b0
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic master_reset_n,
   input wire logic write_clk,
   input wire logic write_enable_n,
   input wire logic [DATA_W-1:0] input_word,
   input wire logic read_clk,
   input wire logic read_enable_n,
   input wire logic output_enable_n,
   output logic [DATA_W-1:0] output_word,
   output logic output_word_oe,
   input wire logic offset_load_n,
   input wire logic first_load_select_n,
   input wire logic write_chain_in_n,
   input wire logic read_chain_in_n,
   output logic empty_flag_n,
   output logic full_flag_n,
   output logic almost_empty_n,
   output logic almost_full_n,
   output logic half_full_n,
   output logic write_chain_out_n,
   output logic read_chain_out_n
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] DEPTH_CNT = (AW+1)'(DEPTH);
   localparam logic [15:0] DEPTH16 = 16'(DEPTH);
   localparam logic [AW-1:0] LAST_LOC = AW'(DEPTH - 1);
   localparam logic [OFS_W-1:0] OFS_RST = default_offset(DEPTH);
   logic [DATA_W-1:0] mem [DEPTH];
   logic wclk_q_r, rclk_q_r;
   logic [AW:0] wptr_r, rptr_r;
   logic [DATA_W-1:0] out_r;
   logic out_valid_r;
   logic [1:0] ft_cnt_r;
   logic fall_through_mode_r, syncflag_r, chain_r;
   logic [OFS_W-1:0] ofs_e_r, ofs_f_r;
   ofs_sel_t wsel_r, rsel_r;
   logic ef1_r, ef2_r, ff1_r, ff2_r;
   logic ae_r, af_r, hf_r, wxo_r, rxo_r;
   logic aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
   logic [ADDR_W-1:0] awaddr_r;
   logic [31:0] wdata_r, rdata_r;
   logic [3:0] wstrb_r;
   logic [1:0] bresp_r, rresp_r;
   // Port clocks are pins sampled on aclk, so either may be tied or unrelated
   wire clr = ~master_reset_n;
   wire wr_edge = write_clk & ~wclk_q_r;
   wire rd_edge = read_clk & ~rclk_q_r;
   wire rd_trans = read_clk ^ rclk_q_r;
   wire wr_req = wr_edge & ~write_enable_n;
   wire rd_req = rd_edge & ~read_enable_n;

   // Occupancy
   wire [AW:0] mem_cnt = wptr_r - rptr_r;
   wire mem_full = (mem_cnt == DEPTH_CNT);
   wire mem_empty = (mem_cnt == '0);
   wire [15:0] tot_w = 16'(mem_cnt) + 16'(fall_through_mode_r & out_valid_r);
   wire [15:0] free_w = (tot_w >= DEPTH16) ? 16'h0000 : DEPTH16 - tot_w;

   // Flags as seen on the pins, in either mode
   wire ef_raw = fall_through_mode_r ? ~out_valid_r : ~mem_empty;
   wire ff_raw = fall_through_mode_r ? mem_full : ~mem_full;
   wire ef_pin = DOUBLE_SYNC ? ef2_r : ef1_r;
   wire ff_pin = DOUBLE_SYNC ? ff2_r : ff1_r;
   // Lagging flag still gates: a stale full flag refuses a write it could take
   wire flag_full = fall_through_mode_r ? ff_pin : ~ff_pin;
   wire room = ~mem_full & ~flag_full;
   wire wr_ok = wr_req & offset_load_n & room;
   wire rd_std = rd_req & offset_load_n & ~fall_through_mode_r & ~mem_empty & ef_pin;
   wire rd_ft = rd_req & offset_load_n & fall_through_mode_r & out_valid_r & ~ef_pin;
   wire ft_ready = (ft_cnt_r == 2'(FT_TRANSITIONS - 1));
   wire load_ft = fall_through_mode_r & ~out_valid_r & ~mem_empty & rd_trans & ft_ready;
   wire pop = rd_std | (rd_ft & ~mem_empty) | load_ft;
   wire ld_wr = wr_req & ~offset_load_n;
   wire ld_rd = rd_req & ~offset_load_n;
   wire ae_raw = tot_w <= 16'(ofs_e_r);
   wire af_raw = free_w <= 16'(ofs_f_r);
   wire hf_raw = tot_w > (DEPTH16 >> 1);

   // Port clock edge detection
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wclk_q_r <= 1'b0;
         rclk_q_r <= 1'b0;
      end else begin
         wclk_q_r <= write_clk;
         rclk_q_r <= read_clk;
      end
   end

   // Mode straps are caught while master reset is held low
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fall_through_mode_r <= 1'b0;
         syncflag_r <= 1'b0;
      end else if (clr) begin
         fall_through_mode_r <= ~read_chain_in_n & first_load_select_n;
         syncflag_r <= ~write_chain_in_n & first_load_select_n;
      end
   end

   // Storage has no reset; pointers define what is valid
   always_ff @(posedge aclk) begin
      if (wr_ok) begin
         mem[wptr_r[AW-1:0]] <= input_word;
      end
   end

   // Write pointer moves only on an accepted write
   always_ff @(posedge aclk) begin
      if (!aresetn || clr) begin
         wptr_r <= '0;
      end else if (wr_ok) begin
         wptr_r <= wptr_r + 1'b1;
      end
   end

   // Read pointer and output register
   always_ff @(posedge aclk) begin
      if (!aresetn || clr) begin
         rptr_r <= '0;
         out_r <= '0;
         out_valid_r <= 1'b0;
      end else if (pop) begin
         rptr_r <= rptr_r + 1'b1;
         out_r <= mem[rptr_r[AW-1:0]];
         out_valid_r <= fall_through_mode_r;
      end else if (ld_rd) begin
         out_r <= DATA_W'((rsel_r == SEL_EMPTY) ? ofs_e_r : ofs_f_r);
      end else if (rd_ft) begin
         out_valid_r <= 1'b0;
      end
   end

   // Fall-through latency counts read clock transitions while a word waits
   always_ff @(posedge aclk) begin
      if (!aresetn || clr || !fall_through_mode_r || out_valid_r || mem_empty) begin
         ft_cnt_r <= 2'h0;
      end else if (rd_trans && !ft_ready) begin
         ft_cnt_r <= ft_cnt_r + 2'h1;
      end
   end

   // Offset registers alternate empty then full on each load access
   always_ff @(posedge aclk) begin
      if (!aresetn || clr) begin
         ofs_e_r <= OFS_RST;
         ofs_f_r <= OFS_RST;
         wsel_r <= SEL_EMPTY;
         rsel_r <= SEL_EMPTY;
      end else begin
         if (ld_wr) begin
            unique case (wsel_r)
               SEL_EMPTY: ofs_e_r <= input_word[OFS_W-1:0];
               SEL_FULL: ofs_f_r <= input_word[OFS_W-1:0];
            endcase
            wsel_r <= (wsel_r == SEL_EMPTY) ? SEL_FULL : SEL_EMPTY;
         end
         if (ld_rd) begin
            rsel_r <= (rsel_r == SEL_EMPTY) ? SEL_FULL : SEL_EMPTY;
         end
      end
   end

   // Flag stages; the second stage trades a cycle of latency for settling
   always_ff @(posedge aclk) begin
      if (!aresetn || clr) begin
         ef1_r <= 1'b0;
         ef2_r <= 1'b0;
         ff1_r <= 1'b1;
         ff2_r <= 1'b1;
      end else begin
         ef1_r <= ef_raw;
         ef2_r <= ef1_r;
         ff1_r <= ff_raw;
         ff2_r <= ff1_r;
      end
   end

   // Almost flags follow aclk, or only their own port clock when synchronous
   always_ff @(posedge aclk) begin
      if (!aresetn || clr) begin
         ae_r <= 1'b0;
         af_r <= 1'b1;
         hf_r <= 1'b1;
      end else begin
         if (!syncflag_r || rd_edge) begin
            ae_r <= ~ae_raw;
         end
         if (!syncflag_r || wr_edge) begin
            af_r <= ~af_raw;
         end
         hf_r <= ~hf_raw;
      end
   end

   // Chain pulses mark the last location written or read
   always_ff @(posedge aclk) begin
      if (!aresetn || clr) begin
         wxo_r <= 1'b1;
         rxo_r <= 1'b1;
      end else begin
         wxo_r <= ~(chain_r & wr_ok & (wptr_r[AW-1:0] == LAST_LOC));
         rxo_r <= ~(chain_r & pop & (rptr_r[AW-1:0] == LAST_LOC));
      end
   end

   assign output_word = out_r;
   assign output_word_oe = ~output_enable_n;
   assign empty_flag_n = ef_pin;
   assign full_flag_n = ff_pin;
   assign almost_empty_n = ae_r;
   assign almost_full_n = af_r;
   assign half_full_n = chain_r | hf_r;
   assign write_chain_out_n = wxo_r;
   assign read_chain_out_n = rxo_r;
   // Register decode, shared by both bus directions
   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      return (a[ADDR_W-1:2] == CTRL_OFS[ADDR_W-1:2]) ||
             (a[ADDR_W-1:2] == STATUS_OFS[ADDR_W-1:2]) ||
             (a[ADDR_W-1:2] == OFFSETS_OFS[ADDR_W-1:2]);
   endfunction : mapped
   wire do_wr = aw_hold_r & w_hold_r & ~bvalid_r;
   wire ctrl_wr = do_wr & (awaddr_r[ADDR_W-1:2] == CTRL_OFS[ADDR_W-1:2]) & wstrb_r[0];
   wire [31:0] status_w = {9'h000, syncflag_r, fall_through_mode_r, hf_r, af_r, ae_r, ff_pin, ef_pin, tot_w};
   wire [31:0] offsets_w = {4'h0, ofs_f_r, 4'h0, ofs_e_r};
   wire [31:0] ctrl_w = {31'h0000_0000, chain_r};
   wire [31:0] rd_mux =
      (araddr[ADDR_W-1:2] == CTRL_OFS[ADDR_W-1:2]) ? ctrl_w :
      (araddr[ADDR_W-1:2] == STATUS_OFS[ADDR_W-1:2]) ? status_w :
      (araddr[ADDR_W-1:2] == OFFSETS_OFS[ADDR_W-1:2]) ? offsets_w : RDATA_RST;

   assign awready = ~aw_hold_r & ~bvalid_r;
   assign wready = ~w_hold_r & ~bvalid_r;
   assign arready = ~rvalid_r;
   assign bvalid = bvalid_r;
   assign bresp = bresp_r;
   assign rvalid = rvalid_r;
   assign rdata = rdata_r;
   assign rresp = rresp_r;
   // Write channel: address and data taken in either order, answered after both
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= '0;
         wstrb_r <= '0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_hold_r <= 1'b1;
            awaddr_r <= awaddr;
         end
         if (wvalid && wready) begin
            w_hold_r <= 1'b1;
            wdata_r <= wdata;
            wstrb_r <= wstrb;
         end
         if (do_wr) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_r && bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // Control register: chain mode steers half-full and the chain pulses
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         chain_r <= CTRL_CHAIN_RST;
      end else if (ctrl_wr) begin
         chain_r <= wdata_r[CTRL_CHAIN_BIT];
      end
   end

   // Read channel answers one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r <= RDATA_RST;
         rresp_r <= RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid_r <= 1'b1;
         rdata_r <= rd_mux;
         rresp_r <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_r && rready) begin
         rvalid_r <= 1'b0;
      end
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   property p_reset_flags;
      !master_reset_n |=> !empty_flag_n && full_flag_n && !almost_empty_n && almost_full_n
         && wptr_r == '0 && rptr_r == '0;
   endproperty
   a_reset_flags: assert property (p_reset_flags) else $error("reset flags wrong");
   property p_full_block;
      (wr_edge && !write_enable_n && mem_full) |=> $stable(wptr_r);
   endproperty
   a_full_block: assert property (p_full_block) else $error("write taken when full");
   property p_idle_write;
      (write_enable_n && master_reset_n) |=> $stable(wptr_r);
   endproperty
   a_idle_write: assert property (p_idle_write) else $error("pointer moved idle");
   property p_write_count;
      (wr_ok && !pop && master_reset_n) |=> mem_cnt == $past(mem_cnt) + 1'b1;
   endproperty
   a_write_count: assert property (p_write_count) else $error("write not counted");
   property p_read_hold;
      (read_enable_n && !fall_through_mode_r && master_reset_n) |=> $stable(output_word);
   endproperty
   a_read_hold: assert property (p_read_hold) else $error("output changed idle");
   // Offset reads may still drive the output register while memory is empty
   property p_empty_block;
      (rd_edge && !fall_through_mode_r && mem_empty && master_reset_n && offset_load_n)
         |=> $stable(rptr_r) && $stable(out_r);
   endproperty
   a_empty_block: assert property (p_empty_block) else $error("read when empty");
   property p_oe;
      output_enable_n |-> !output_word_oe;
   endproperty
   a_oe: assert property (p_oe) else $error("bus driven when disabled");
   property p_fall_through;
      (master_reset_n && load_ft) |=> out_valid_r ##1 !empty_flag_n;
   endproperty
   a_fall_through: assert property (p_fall_through) else $error("first word not ready");
   property p_half_full;
      (master_reset_n && !chain_r && hf_raw && !ctrl_wr) |=> !half_full_n;
   endproperty
   a_half_full: assert property (p_half_full) else $error("half full missing");
   property p_read_answer;
      (arvalid && arready) |=> rvalid ##0 rdata == $past(rd_mux);
   endproperty
   a_read_answer: assert property (p_read_answer) else $error("read answer late");
   c_full: cover property (mem_full && !full_flag_n);
   c_fall_through: cover property (load_ft);
   c_offset_load: cover property (ld_wr ##[1:50] ld_rd);
   c_chain_pulse: cover property (!write_chain_out_n);
endmodule : dual_clock_fifo_18bit_flags
`default_nettype wire

//--- testbench/port_clk_model.sv
// Far-side port clocks: a free-running write clock and a stoppable read clock
`default_nettype none
module port_clk_model
   import fifo_pkg::*;
#(
   parameter int W_HALF = 2,
   parameter int R_HALF = 3
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic read_run,
   output logic write_clk,
   output logic read_clk
);
   timeunit 1ns;
   timeprecision 100ps;
   int wcnt;
   int rcnt;
   // Unequal half periods keep the two port clocks drifting against each other
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wcnt <= 0;
         rcnt <= 0;
         write_clk <= 1'b0;
         read_clk <= 1'b0;
      end else begin
         wcnt <= (wcnt == W_HALF - 1) ? 0 : wcnt + 1;
         if (wcnt == W_HALF - 1) write_clk <= !write_clk;
         // Read clock finishes its high phase and then rests low, so no stray transitions
         if (read_run || read_clk) begin
            rcnt <= (rcnt == R_HALF - 1) ? 0 : rcnt + 1;
            if (rcnt == R_HALF - 1) read_clk <= !read_clk;
         end
      end
   end
endmodule : port_clk_model
`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench for the flagged FIFO: scoreboard, port traffic, status reads
`default_nettype none
module tb
   import fifo_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int D = DEPTH_DEF;
   logic aclk = 1'b0, aresetn = 1'b0, master_reset_n = 1'b0, read_run = 1'b1;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata;
   logic [3:0] wstrb = 4'hF;
   logic [1:0] bresp, rresp;
   logic awready, wready, bvalid, arready, rvalid, write_clk, read_clk, output_word_oe;
   logic write_enable_n = 1'b1, read_enable_n = 1'b1, output_enable_n = 1'b1;
   logic offset_load_n = 1'b1, first_load_select_n = 1'b1, read_chain_in_n = 1'b1;
   logic write_chain_in_n = 1'b1;
   logic empty_flag_n, full_flag_n, almost_empty_n, almost_full_n, half_full_n;
   logic [DATA_W-1:0] input_word = '0, output_word, exp_next;
   logic wclk_q = 1'b0, rclk_q = 1'b0, pend = 1'b0, ft = 1'b0, wsel, rsel;
   logic [OFS_W-1:0] ofs_m [2];
   logic [DATA_W-1:0] exp_q [$];
   logic [33:0] ax_q [$];
   int cnt = 0, mismatches = 0, samples_checked = 0, cycles = 0, tr;
   int steps [7] = '{31, 1, 96, 1, 95, 1, 31};
   wire logic wr_evt = write_clk & !wclk_q;
   wire logic rd_evt = read_clk & !rclk_q;

   always #25 aclk = ~aclk;

   dual_clock_fifo_18bit_flags DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .master_reset_n(master_reset_n), .write_clk(write_clk),
      .write_enable_n(write_enable_n), .input_word(input_word), .read_clk(read_clk),
      .read_enable_n(read_enable_n), .output_enable_n(output_enable_n),
      .output_word(output_word), .output_word_oe(output_word_oe),
      .offset_load_n(offset_load_n), .first_load_select_n(first_load_select_n),
      .write_chain_in_n(write_chain_in_n), .read_chain_in_n(read_chain_in_n),
      .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n),
      .almost_empty_n(almost_empty_n), .almost_full_n(almost_full_n),
      .half_full_n(half_full_n), .write_chain_out_n(), .read_chain_out_n());

   port_clk_model clocks (.aclk(aclk), .aresetn(aresetn), .read_run(read_run),
      .write_clk(write_clk), .read_clk(read_clk));

   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic tally_and_finish();
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : tally_and_finish

   // Flag levels expected from the model count with the reset offsets of 31 words
   task automatic flags_std();
      chk({29'h0, empty_flag_n, full_flag_n, almost_empty_n, almost_full_n, half_full_n},
         {29'h0, cnt != 0, cnt != D, cnt > 31, (D - cnt) > 31, cnt <= D / 2});
   endtask : flags_std

   // Holds the enable low for exactly n port clock rises, fresh random data each rise
   task automatic xfer(input bit rd, input int n);
      int k;
      k = 0;
      if (rd) read_enable_n <= 1'b0;
      else write_enable_n <= 1'b0;
      input_word <= DATA_W'($urandom);
      while (k < n) begin
         @(posedge aclk);
         if (rd ? rd_evt : wr_evt) begin
            k++;
            input_word <= DATA_W'($urandom);
         end
      end
      read_enable_n <= 1'b1;
      write_enable_n <= 1'b1;
      repeat (4) @(posedge aclk);
   endtask : xfer

   task automatic mreset(input bit f);
      read_chain_in_n <= !f;
      write_chain_in_n <= !f;
      master_reset_n <= 1'b0;
      repeat (2) @(posedge aclk);
      master_reset_n <= 1'b1;
      repeat (3) @(posedge aclk);
   endtask : mreset

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      ax_q.push_back({r, 32'h0});
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      @(posedge aclk);
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, input logic [33:0] exp);
      ax_q.push_back(exp);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      @(posedge aclk);
   endtask : axi_rd

   // Monitor: mirrors pin-sampled events, keeps the word notes, compares answers
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         tally_and_finish();
      end
      wclk_q <= write_clk;
      rclk_q <= read_clk;
      chk({33'h0, output_word_oe}, {33'h0, !output_enable_n});
      output_enable_n <= 1'($urandom);
      if (bvalid && bready) chk({bresp, 32'h0}, ax_q.pop_front());
      if (rvalid && rready) chk({rresp, rdata}, ax_q.pop_front());
      if (pend) chk({16'h0, output_word}, {16'h0, exp_next});
      // Fall-through output moves without reads, so only standard mode is scored here
      pend <= rd_evt && !ft && master_reset_n;
      if (!master_reset_n) begin
         cnt = 0;
         exp_q.delete();
         wsel = 1'b0;
         rsel = 1'b0;
         ofs_m = '{12'h01F, 12'h01F};
         ft <= !read_chain_in_n & first_load_select_n;
      end else begin
         if (wr_evt && !write_enable_n) begin
            if (!offset_load_n) begin
               ofs_m[wsel] = input_word[OFS_W-1:0];
               wsel = !wsel;
            end else if (cnt < D) begin
               exp_q.push_back(input_word);
               cnt++;
            end
         end
         if (rd_evt) begin
            if (!offset_load_n && !read_enable_n) begin
               exp_next <= {6'h0, ofs_m[rsel]};
               rsel = !rsel;
            end else if (!read_enable_n && cnt > 0) begin
               exp_next <= exp_q.pop_front();
               cnt--;
            end else exp_next <= output_word;
         end
      end
   end

   initial begin
      void'($urandom(32'h106b94fe));
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      mreset(1'b0);
      flags_std();
      axi_rd(OFFSETS_OFS, {RESP_OKAY, 32'h001F_001F});
      axi_rd(8'h40, {RESP_SLVERR, 32'h0});
      axi_wr(8'h40, 32'h1, RESP_SLVERR);
      // Fill in steps that land on each flag boundary, then push past full
      foreach (steps[i]) begin
         xfer(1'b0, steps[i]);
         flags_std();
      end
      xfer(1'b0, 4);
      flags_std();
      axi_rd(STATUS_OFS, {RESP_OKAY, 32'h0005_0000 | 32'(D)});
      axi_wr(CTRL_OFS, 32'h1, RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk({33'h0, half_full_n}, 34'h1);
      axi_rd(CTRL_OFS, {RESP_OKAY, 32'h1});
      axi_wr(CTRL_OFS, 32'h0, RESP_OKAY);
      foreach (steps[i]) begin
         xfer(1'b1, steps[i]);
         flags_std();
      end
      xfer(1'b1, 3);
      flags_std();
      offset_load_n <= 1'b0;
      xfer(1'b0, 2);
      xfer(1'b1, 2);
      offset_load_n <= 1'b1;
      axi_rd(OFFSETS_OFS, {RESP_OKAY, 4'h0, ofs_m[1], 4'h0, ofs_m[0]});
      // Fall-through: read clock parked, so the word must wait for transitions
      read_run <= 1'b0;
      mreset(1'b1);
      // Parked read clock: synchronous almost-empty keeps its reset level
      axi_rd(STATUS_OFS, {RESP_OKAY, 32'h0079_0000});
      xfer(1'b0, 1);
      repeat (10) @(posedge aclk);
      chk({32'h0, empty_flag_n, full_flag_n}, 34'h2);
      read_run <= 1'b1;
      tr = 0;
      for (int k = 0; k < 60 && empty_flag_n !== 1'b0; k++) begin
         @(posedge aclk);
         if (read_clk !== rclk_q) tr++;
      end
      chk(34'(tr), 34'(FT_TRANSITIONS));
      chk({16'h0, output_word}, {16'h0, exp_q.pop_front()});
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire
